// ### gtc_edge_arm.sv
// gtc_edge_arm.sv: arms external rising-edge counting after a falling edge is seen
// assumes: pin level already sampled in mclk domain; enable is timer on with the external source selected
`timescale 1ns/1ps
`default_nettype none
module gtc_edge_arm (
  input wire logic mclk,
  input wire logic rst,
  input wire logic enable,
  input wire logic pin_now,
  input wire logic pin_prev,
  output logic count_edge
);
  gtc_pkg::gtc_arm_t state_ff;
  gtc_pkg::gtc_arm_t nxt_state;
  always_comb begin
    nxt_state = state_ff;
    count_edge = 1'b0;
    case (state_ff)
      gtc_pkg::GTC_ARM_WAIT_LOW: begin
        if (enable && pin_prev && !pin_now) begin
          nxt_state = gtc_pkg::GTC_ARM_READY; // [R4]
        end
      end
      gtc_pkg::GTC_ARM_WAIT_FALL: nxt_state = gtc_pkg::GTC_ARM_WAIT_LOW;
      gtc_pkg::GTC_ARM_READY: begin
        if (!enable) begin
          nxt_state = gtc_pkg::GTC_ARM_WAIT_LOW; // [R4]
        end else begin
          count_edge = !pin_prev && pin_now; // [R2]
        end
      end
      default: nxt_state = gtc_pkg::GTC_ARM_WAIT_LOW;
    endcase
  end
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_ff <= gtc_pkg::GTC_ARM_WAIT_LOW;
    end else begin
      state_ff <= nxt_state;
    end
  end
endmodule : gtc_edge_arm
`default_nettype wire

// ### gtc_ext_src.sv
// gtc_ext_src.sv: external count clock source model
// assumes: clock stands still at its level between bursts
`timescale 1ns/1ps
`default_nettype none
module gtc_ext_src (
  input wire logic mclk,
  output logic ext_clk
);
  initial ext_clk = 1'b1;
  task automatic level(input logic b);
    @(posedge mclk);
    ext_clk <= b;
  endtask : level
  task automatic wave(input int n, input int half);
    for (int i = 0; i < 2 * n; i++) begin
      @(posedge mclk);
      ext_clk <= ~ext_clk;
      repeat (half - 1) @(posedge mclk);
    end
  endtask : wave
endmodule : gtc_ext_src
`default_nettype wire

// ### gtc_params.svh
// gtc_params.svh: register offsets, field positions, reset values for the gated timer
// assumes: included by the timer, checker and bench modules by bare name
`ifndef GTC_PARAMS_SVH
`define GTC_PARAMS_SVH
`define GTC_OFF_CTRL 8'h00
`define GTC_OFF_CNT_LO 8'h04
`define GTC_OFF_CNT_HI 8'h08
`define GTC_OFF_STATUS 8'h0C
`define GTC_OFF_GATE 8'h10
`define GTC_OFF_PORTA 8'h14
`define GTC_CTRL_ON 0
`define GTC_CTRL_CLKSRC 1
`define GTC_CTRL_SYNCDIS 2
`define GTC_CTRL_OSCEN 3
`define GTC_CTRL_PS_LO 4
`define GTC_CTRL_PS_HI 5
`define GTC_GATE_EN 0
`define GTC_GATE_SRC 1
`define GTC_GATE_INV 2
`define GTC_CTRL_RST 8'h00
`define GTC_GATE_RST 8'h00
`define GTC_DIR_RST 2'b11
`endif

// ### gtc_pkg.sv
// gtc_pkg.sv: types shared by the gated timer modules
// assumes: nothing beyond the language
package gtc_pkg;
  typedef struct packed {
    logic [1:0] prescale_select;
    logic lp_osc_enable;
    logic sync_disable;
    logic clk_src_ext;
    logic timer_on;
  } gtc_ctrl_t;
  typedef struct packed {
    logic gate_invert;
    logic gate_src_cmp;
    logic gate_en;
  } gtc_gate_t;
  typedef enum logic [1:0] {GTC_ARM_WAIT_LOW, GTC_ARM_WAIT_FALL, GTC_ARM_READY} gtc_arm_t;
endpackage : gtc_pkg

// ### gtc_timer.sv
// gtc_timer.sv: 16-bit gated timer/counter with prescaler, wishbone register slave
// assumes: classic wishbone master on mclk; pins synchronous to mclk
//
// Summary of operation
// [R1] internal source counts mclk divided by the prescale ratio
// [R2] external source counts rising edges of the external clock pin
// [R3] software picks synchronized or unsynchronized external counting
// [R4] a falling edge must precede the first counted rising edge after enable
// [R5] prescale ratios 1, 2, 4, 8 from a two-bit select field
// [R6] prescaler hidden; cleared on any write to either count byte
// [R7] crystal oscillator enabled only while the oscillator enable bit is set
// [R8] oscillator keeps running while the processor sleeps
// [R9] software uses the oscillator only with internal or low-power crystal clock
// [R10] oscillator on forces pin 4/5 direction to input; data bits read zero
// [R11] software waits for oscillator start-up before enabling the timer
// [R12] sync disable bit counts the external clock without the sync stage
// [R13] unsynchronized external counting runs in sleep, overflow wakes processor
// [R14] switching sync mode may lose or add one increment
// [R15] reads of either byte while counting return a coherent value
// [R16] software should stop the timer before writing the count bytes
// [R17] with gating enabled, count only while the gate is active
// [R18] gate source is the gate pin or the second comparator output
// [R19] count only while timer on is set, else hold
// [R20] rollover wraps to zero and sets a sticky overflow flag and request
//
// Decided for this implementation: the Wishbone register port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "gtc_params.svh"
module gtc_timer (
  input wire logic mclk,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic ext_count_clock_pin,
  input wire logic gate_pin,
  input wire logic second_comparator,
  input wire logic sleep,
  input wire logic porta_pin5,
  input wire logic porta_pin4,
  output logic lp_osc_run,
  output logic overflow_irq,
  output logic porta_dir_bit5,
  output logic porta_dir_bit4
);
  gtc_pkg::gtc_ctrl_t ctrl_ff;
  gtc_pkg::gtc_gate_t gate_ff;
  logic [15:0] count_ff;
  logic [2:0] presc_ff;
  logic ovf_ff;
  logic [1:0] dir_ff;
  logic ext_s1_ff;
  logic ext_s2_ff;
  logic ext_prev_ff;
  logic ext_raw_prev_ff;
  logic [31:0] nxt_dat;
  logic ack_ff;
  logic [31:0] dat_ff;
  logic lp_osc_ff;
  logic irq_ff;
  logic dir5_ff;
  logic dir4_ff;
  logic bus_req;
  logic wr_lo;
  logic wr_hi;
  logic ext_now;
  logic ext_prev;
  logic ext_edge;
  logic gate_active;
  logic tick;
  logic presc_hit;
  logic [16:0] inc_sum;

  function automatic logic [2:0] ratio_mask(input logic [1:0] sel);
    case (sel)
      2'b00: ratio_mask = 3'b000;
      2'b01: ratio_mask = 3'b001;
      2'b10: ratio_mask = 3'b011;
      default: ratio_mask = 3'b111;
    endcase
  endfunction : ratio_mask

  function automatic logic byte_hit(input logic [7:0] adr, input logic [7:0] off);
    byte_hit = (adr == off);
  endfunction : byte_hit

  // bus strobes: one request per cycle, ack drops the cycle after it rose
  assign bus_req = wb_cyc_i && wb_stb_i && !ack_ff;
  assign wr_lo = bus_req && wb_we_i && wb_sel_i[0] && byte_hit(wb_adr_i, `GTC_OFF_CNT_LO);
  assign wr_hi = bus_req && wb_we_i && wb_sel_i[0] && byte_hit(wb_adr_i, `GTC_OFF_CNT_HI);

  // external pin: synchronized path or direct (raw sampled) path
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ext_s1_ff <= 1'b0;
      ext_s2_ff <= 1'b0;
      ext_prev_ff <= 1'b0;
      ext_raw_prev_ff <= 1'b0;
    end else begin
      ext_s1_ff <= ext_count_clock_pin;
      ext_s2_ff <= ext_s1_ff;
      ext_prev_ff <= ext_s2_ff;
      ext_raw_prev_ff <= ext_count_clock_pin;
    end
  end
  assign ext_now = ctrl_ff.sync_disable ? ext_count_clock_pin : ext_s2_ff; // [R3] [R12] [R14]
  assign ext_prev = ctrl_ff.sync_disable ? ext_raw_prev_ff : ext_prev_ff; // [R12]

  gtc_edge_arm u_arm (
    .mclk(mclk),
    .rst(rst),
    .enable(ctrl_ff.timer_on && ctrl_ff.clk_src_ext),
    .pin_now(ext_now),
    .pin_prev(ext_prev),
    .count_edge(ext_edge)
  );

  // gate selection and polarity
  assign gate_active = !gate_ff.gate_en ||
    ((gate_ff.gate_src_cmp ? second_comparator : gate_pin) ^ gate_ff.gate_invert); // [R17] [R18]

  // synchronized counting stalls in sleep; unsynchronized counting keeps going
  assign tick = ctrl_ff.clk_src_ext ? (ext_edge && (ctrl_ff.sync_disable || !sleep))
                                    : !sleep; // [R1] [R2] [R13]
  assign presc_hit = ((presc_ff & ratio_mask(ctrl_ff.prescale_select)) ==
                      ratio_mask(ctrl_ff.prescale_select)); // [R5]
  assign inc_sum = {1'b0, count_ff} + 17'h0_0001;

  // prescaler, not visible on the bus
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      presc_ff <= 3'h0;
    end else if (wr_lo || wr_hi) begin
      presc_ff <= 3'h0; // [R6]
    end else if (ctrl_ff.timer_on && gate_active && tick) begin
      presc_ff <= presc_ff + 3'h1; // [R5]
    end
  end

  // counter pair
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      count_ff <= 16'h0000;
    end else if (wr_lo) begin
      count_ff <= {count_ff[15:8], wb_dat_i[7:0]}; // [R16]
    end else if (wr_hi) begin
      count_ff <= {wb_dat_i[7:0], count_ff[7:0]}; // [R16]
    end else if (ctrl_ff.timer_on && gate_active && tick && presc_hit) begin
      count_ff <= inc_sum[15:0]; // [R1] [R19] [R20]
    end
  end

  // sticky overflow: the set wins over a software clear
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ovf_ff <= 1'b0;
    end else if (ctrl_ff.timer_on && gate_active && tick && presc_hit && inc_sum[16]
                 && !wr_lo && !wr_hi) begin
      ovf_ff <= 1'b1; // [R20]
    end else if (bus_req && wb_we_i && wb_sel_i[0] && byte_hit(wb_adr_i, `GTC_OFF_STATUS)
                 && wb_dat_i[0]) begin
      ovf_ff <= 1'b0;
    end
  end

  // control and gate registers
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ctrl_ff <= gtc_pkg::gtc_ctrl_t'(6'(`GTC_CTRL_RST));
      gate_ff <= gtc_pkg::gtc_gate_t'(3'(`GTC_GATE_RST));
    end else if (bus_req && wb_we_i && wb_sel_i[0]) begin
      if (byte_hit(wb_adr_i, `GTC_OFF_CTRL)) begin
        ctrl_ff.timer_on <= wb_dat_i[`GTC_CTRL_ON]; // [R19]
        ctrl_ff.clk_src_ext <= wb_dat_i[`GTC_CTRL_CLKSRC];
        ctrl_ff.sync_disable <= wb_dat_i[`GTC_CTRL_SYNCDIS]; // [R3]
        ctrl_ff.lp_osc_enable <= wb_dat_i[`GTC_CTRL_OSCEN]; // [R7]
        ctrl_ff.prescale_select <= wb_dat_i[`GTC_CTRL_PS_HI:`GTC_CTRL_PS_LO]; // [R5]
      end
      if (byte_hit(wb_adr_i, `GTC_OFF_GATE)) begin
        gate_ff.gate_en <= wb_dat_i[`GTC_GATE_EN]; // [R17]
        gate_ff.gate_src_cmp <= wb_dat_i[`GTC_GATE_SRC]; // [R18]
        gate_ff.gate_invert <= wb_dat_i[`GTC_GATE_INV];
      end
    end
  end

  // port a direction bits 5:4, forced to input while the oscillator runs
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      dir_ff <= `GTC_DIR_RST;
    end else if (ctrl_ff.lp_osc_enable) begin
      dir_ff <= 2'b11; // [R10]
    end else if (bus_req && wb_we_i && wb_sel_i[0] && byte_hit(wb_adr_i, `GTC_OFF_PORTA)) begin
      dir_ff <= wb_dat_i[5:4];
    end
  end

  // read mux; count bytes come from one register so each read is coherent
  always_comb begin
    nxt_dat = 32'h0000_0000;
    if (byte_hit(wb_adr_i, `GTC_OFF_CTRL)) begin
      nxt_dat[5:0] = {ctrl_ff.prescale_select, ctrl_ff.lp_osc_enable,
                      ctrl_ff.sync_disable, ctrl_ff.clk_src_ext, ctrl_ff.timer_on};
    end else if (byte_hit(wb_adr_i, `GTC_OFF_CNT_LO)) begin
      nxt_dat[7:0] = count_ff[7:0]; // [R15]
    end else if (byte_hit(wb_adr_i, `GTC_OFF_CNT_HI)) begin
      nxt_dat[7:0] = count_ff[15:8]; // [R15]
    end else if (byte_hit(wb_adr_i, `GTC_OFF_STATUS)) begin
      nxt_dat[0] = ovf_ff;
    end else if (byte_hit(wb_adr_i, `GTC_OFF_GATE)) begin
      nxt_dat[2:0] = {gate_ff.gate_invert, gate_ff.gate_src_cmp, gate_ff.gate_en};
    end else if (byte_hit(wb_adr_i, `GTC_OFF_PORTA)) begin
      nxt_dat[5:4] = dir_ff;
      nxt_dat[13:12] = ctrl_ff.lp_osc_enable ? 2'b00 : {porta_pin5, porta_pin4}; // [R10]
    end
  end

  // bus answer, one cycle after the request; unmapped reads return zero
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ack_ff <= 1'b0;
      dat_ff <= 32'h0000_0000;
    end else begin
      ack_ff <= bus_req;
      dat_ff <= bus_req ? nxt_dat : 32'h0000_0000;
    end
  end

  // registered outputs; oscillator enable ignores sleep
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      lp_osc_ff <= 1'b0;
      irq_ff <= 1'b0;
      dir5_ff <= 1'b1;
      dir4_ff <= 1'b1;
    end else begin
      lp_osc_ff <= ctrl_ff.lp_osc_enable; // [R7] [R8]
      irq_ff <= ovf_ff; // [R13] [R20]
      dir5_ff <= dir_ff[1] | ctrl_ff.lp_osc_enable; // [R10]
      dir4_ff <= dir_ff[0] | ctrl_ff.lp_osc_enable; // [R10]
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = dat_ff;
  assign lp_osc_run = lp_osc_ff;
  assign overflow_irq = irq_ff;
  assign porta_dir_bit5 = dir5_ff;
  assign porta_dir_bit4 = dir4_ff;
endmodule : gtc_timer
`default_nettype wire

// ### gtc_timer_assertions.sv
// gtc_timer_assertions.sv: port checker for the gated timer
// assumes: bound into gtc_timer, one clock mclk, async reset rst
`timescale 1ns/1ps
`default_nettype none
`include "gtc_params.svh"
module gtc_timer_assertions (
  input wire logic mclk,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic ext_count_clock_pin,
  input wire logic gate_pin,
  input wire logic second_comparator,
  input wire logic sleep,
  input wire logic porta_pin5,
  input wire logic porta_pin4,
  input wire logic lp_osc_run,
  input wire logic overflow_irq,
  input wire logic porta_dir_bit5,
  input wire logic porta_dir_bit4
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  wire logic take = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire logic wr0 = take && wb_we_i && wb_sel_i[0];
  wire logic wr_ctrl = wr0 && wb_adr_i == `GTC_OFF_CTRL;
  wire logic wr_clr = wr0 && wb_adr_i == `GTC_OFF_STATUS && wb_dat_i[0];
  wire logic rd_pa = take && !wb_we_i && wb_adr_i == `GTC_OFF_PORTA;
  wire logic rd_bad = take && !wb_we_i && wb_adr_i > `GTC_OFF_PORTA;
  sequence s_take; take; endsequence
  sequence s_answer; wb_ack_o ##1 !wb_ack_o; endsequence
  a_ack_one_pulse: assert property (s_take |=> s_answer)
    else $error("ack not a single pulse after request");
  a_no_idle_ack: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("ack without request");
  a_dat_quiet: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
    else $error("read data outside ack");
  a_unmapped_zero: assert property (rd_bad |=> wb_dat_o == 32'h0000_0000)
    else $error("unmapped read not zero");
  a_osc_follows_bit: assert property (wr_ctrl |-> ##2
    lp_osc_run == $past(wb_dat_i[`GTC_CTRL_OSCEN], 2)) else $error("osc enable mismatch");
  a_osc_only_write: assert property ($changed(lp_osc_run) |-> $past(wr_ctrl, 2))
    else $error("osc changed without control write");
  a_dir_forced: assert property (lp_osc_run |-> porta_dir_bit5 && porta_dir_bit4)
    else $error("direction not forced to input");
  a_pins_read_zero: assert property (rd_pa && lp_osc_run |=> wb_dat_o[13:12] == 2'b00)
    else $error("pin bits not zero with osc on");
  a_irq_sticky: assert property (overflow_irq && !wr_clr && !$past(wr_clr) |=> overflow_irq)
    else $error("overflow flag dropped without clear");
endmodule : gtc_timer_assertions
bind gtc_timer gtc_timer_assertions i_gtc_timer_assertions (.*);
`default_nettype wire

// ### gtc_timer_tb.sv
// gtc_timer_tb.sv: self-checking bench for gtc_timer
// assumes: gtc_ext_src drives the external count clock
`timescale 1ns/1ps
`default_nettype none
`include "gtc_params.svh"
module gtc_timer_tb;
  logic mclk, rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, ext_count_clock_pin;
  logic gate_pin, second_comparator, sleep, porta_pin5, porta_pin4;
  logic lp_osc_run, overflow_irq, porta_dir_bit5, porta_dir_bit4;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, q;
  logic [15:0] c, c2;
  int fail_count = 0, compares = 0, seed = 32'h5928_3f9e, w, n;
  gtc_timer i_gtc_timer (.*);
  gtc_ext_src i_gtc_ext_src (.mclk(mclk), .ext_clk(ext_count_clock_pin));
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  task automatic print_verdict();
    if (fail_count == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  function automatic logic close(input logic [15:0] s, input logic [15:0] e);
    logic [15:0] d;
    d = s - e + 16'h0001;
    return d <= 16'h0002;
  endfunction : close
  task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d);
    int i;
    i = 0;
    @(posedge mclk);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, we, a, d};
    do begin
      @(posedge mclk);
      i++;
    end while (wb_ack_o !== 1'b1 && i < 20);
    if (i >= 20) begin
      fail_count++;
      print_verdict();
    end
    q = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'b00;
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    bus(1'b0, a, 32'h0000_0000);
  endtask : rd
  task automatic clear_count();
    wr(`GTC_OFF_CNT_LO, 32'h0000_0000);
    wr(`GTC_OFF_CNT_HI, 32'h0000_0000);
  endtask : clear_count
  task automatic getc(output logic [15:0] v);
    rd(`GTC_OFF_CNT_LO);
    v[7:0] = q[7:0];
    rd(`GTC_OFF_CNT_HI);
    v[15:8] = q[7:0];
  endtask : getc
  task automatic run(input logic [31:0] ctl, input int cyc);
    wr(`GTC_OFF_CTRL, ctl | 32'h0000_0001);
    repeat (cyc) @(posedge mclk);
    wr(`GTC_OFF_CTRL, ctl);
  endtask : run
  initial begin
    {wb_cyc_i, wb_stb_i, wb_we_i, gate_pin, second_comparator, sleep} = '0;
    {wb_adr_i, wb_dat_i, porta_pin5, porta_pin4, rst, wb_sel_i} = {40'h0, 3'b111, 4'h1};
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    rd(`GTC_OFF_CTRL);
    chk(q, `GTC_CTRL_RST, "ctrl reset");
    rd(`GTC_OFF_GATE);
    chk(q, `GTC_GATE_RST, "gate reset");
    rd(`GTC_OFF_PORTA);
    chk(q[5:4], `GTC_DIR_RST, "dir reset");
    wr(8'h40, 32'hffff_ffff);
    rd(8'h40);
    chk(q, 32'h0000_0000, "unmapped");
    for (int p = 0; p < 4; p++) begin
      w = 32 + ($random(seed) & 63);
      clear_count();
      run(p << 4, w);
      getc(c);
      chk(c, 16'((w + 3) >> p), "prescaled count");
      repeat (20) @(posedge mclk);
      getc(c2);
      chk(c2, c, "held count");
    end
    for (int m = 0; m < 4; m++) begin
      n = 2 + ($random(seed) & 7);
      i_gtc_ext_src.level(!m[1]);
      clear_count();
      wr(`GTC_OFF_CTRL, 32'h0000_0003 | (m[0] << 2));
      sleep <= m[0];
      i_gtc_ext_src.wave(n, 4);
      repeat (8) @(posedge mclk);
      sleep <= 1'b0;
      wr(`GTC_OFF_CTRL, 32'h0000_0000);
      getc(c);
      chk(c, n - m[1], "ext count");
    end
    for (int s = 0; s < 2; s++) begin
      clear_count();
      {second_comparator, gate_pin} <= s ? 2'b01 : 2'b10;
      wr(`GTC_OFF_GATE, 1 | (s << 1));
      run(0, 40);
      getc(c);
      chk(c, 0, "gated off");
      {second_comparator, gate_pin} <= s ? 2'b10 : 2'b01;
      run(0, 40);
      getc(c);
      chk(close(c, 16'd43), 1, "gated on");
    end
    {second_comparator, gate_pin} <= 2'b01;
    wr(`GTC_OFF_GATE, 32'h0000_0005);
    clear_count();
    run(0, 40);
    getc(c);
    chk(c, 0, "inverted gate off");
    gate_pin <= 1'b0;
    run(0, 40);
    getc(c);
    chk(close(c, 16'd43), 1, "inverted gate on");
    w = $random(seed);
    {porta_pin5, porta_pin4} <= w[1:0];
    wr(`GTC_OFF_GATE, 32'h0000_0000);
    wr(`GTC_OFF_PORTA, 32'h0000_0000);
    rd(`GTC_OFF_PORTA);
    chk(q[13:12], w[1:0], "pins read");
    chk({q[5:4], porta_dir_bit5, porta_dir_bit4}, 4'h0, "dir written");
    {porta_pin5, porta_pin4} <= 2'b11;
    wr(`GTC_OFF_CTRL, 32'h0000_0008);
    sleep <= 1'b1;
    repeat (4) @(posedge mclk);
    chk({lp_osc_run, porta_dir_bit5, porta_dir_bit4}, 3'b111, "osc on");
    sleep <= 1'b0;
    rd(`GTC_OFF_PORTA);
    chk({q[13:12], q[5:4]}, 4'h3, "pins masked");
    wr(`GTC_OFF_CNT_LO, 32'h0000_00fe);
    wr(`GTC_OFF_CNT_HI, 32'h0000_00ff);
    run(32'h0000_0008, 10);
    getc(c);
    chk(close(c, 16'h000b), 1, "wrapped count");
    chk(overflow_irq, 1'b1, "irq set");
    rd(`GTC_OFF_STATUS);
    chk(q[0], 1'b1, "flag");
    wr(`GTC_OFF_STATUS, 32'h0000_0001);
    repeat (2) @(posedge mclk);
    chk(overflow_irq, 1'b0, "irq cleared");
    wr(`GTC_OFF_CTRL, 32'h0000_0000);
    repeat (2) @(posedge mclk);
    chk({lp_osc_run, porta_dir_bit5, porta_dir_bit4}, 3'b011, "osc off");
    print_verdict();
  end
endmodule : gtc_timer_tb
`default_nettype wire
